//--- core/program_event_trap_pkg.sv
// Purpose: Shared constants and types of the program event trap unit.
// Assumes: 200 MHz hclk, AHB-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses of aligned words.

package program_event_trap_pkg;

    // ==================================================================
    // Widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int PHASE_W = 8;
    localparam int MODE_W = 8;
    localparam int CODE_W = 4;
    localparam int TOTAL_W = 32;

    // ==================================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DEFAULT_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ACTIVE_MODE = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_INFUSED = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_WITHDRAWN = 8'h14;

    // ==================================================================
    // Command word layout and codes
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_PARAM_LSB = 8;
    localparam logic [CODE_W-1:0] CMD_NONE = 4'h0;
    localparam logic [CODE_W-1:0] CMD_TRAP_FALLING = 4'h1;
    localparam logic [CODE_W-1:0] CMD_TRAP_SQUARE = 4'h2;
    localparam logic [CODE_W-1:0] CMD_TRAP_CANCEL = 4'h3;
    localparam logic [CODE_W-1:0] CMD_CLEAR_TOTALS = 4'h4;
    localparam logic [CODE_W-1:0] CMD_TRIGGER_OVERRIDE = 4'h5;
    localparam logic [CODE_W-1:0] CMD_BUTTON_REDIRECT = 4'h6;
    localparam logic [CODE_W-1:0] CMD_TRIGGER_REDIRECT = 4'h7;
    localparam logic [CODE_W-1:0] CMD_OUTPUT_SET = 4'h8;
    localparam logic [CODE_W-1:0] CMD_BEEP = 4'h9;

    // ==================================================================
    // Status word bit positions
    localparam int ST_ARMED = 0;
    localparam int ST_SQUARE = 1;
    localparam int ST_BUTTON_REDIRECT = 2;
    localparam int ST_TRIGGER_REDIRECT = 3;
    localparam int ST_OUTPUT = 4;
    localparam int ST_BUZZER = 5;
    localparam int ST_PHASE_LSB = 8;

    // ==================================================================
    // Reset values and bus codes
    localparam logic [MODE_W-1:0] DEFAULT_MODE_RESET = 8'h00;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // ==================================================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int LOW_HOLD_MS = 200;
    localparam int BEEP_MS = 100;
    localparam int LOW_HOLD_CYCLES = LOW_HOLD_MS * 1000 * CLK_MHZ;
    localparam int BEEP_CYCLES = BEEP_MS * 1000 * CLK_MHZ;

    // ==================================================================
    // Types
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [PHASE_W-1:0] param;
    } command_type;

    typedef struct packed {
        logic rise;
        logic fall;
        logic low_held;
    } event_flags_type;

    typedef enum logic [1:0] {
        TRAP_IDLE,
        TRAP_FALLING,
        TRAP_SQUARE
    } trap_state_type;

endpackage : program_event_trap_pkg

//--- core/event_input_conditioner.sv
// Purpose: Synchronises the event pin, finds its edges, times a low level.
// Assumes: One clock; the pin may change at any time.
// Notes: The low timer saturates at the hold count.

`timescale 1ns/1ps
`default_nettype none

module event_input_conditioner
    import program_event_trap_pkg::*;
#(
    parameter int HOLD_CYCLES = LOW_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Raw pin
    input wire logic event_pin,
    // Conditioned result
    output event_flags_type flags
);

    // ==================================================================
    // Two-stage synchroniser and edge history
    logic sync_first;
    logic sync_level;
    logic level_prev;
    logic [31:0] low_count;
    logic low_full;

    assign low_full = (low_count >= 32'(HOLD_CYCLES));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_first <= 1'b1;
            sync_level <= 1'b1;
            level_prev <= 1'b1;
        end else begin
            sync_first <= event_pin;
            sync_level <= sync_first;
            level_prev <= sync_level;
        end
    end

    // ==================================================================
    // Low-level timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_count <= 32'h0000_0000;
        end else if (sync_level) begin
            low_count <= 32'h0000_0000;
        end else if (!low_full) begin
            low_count <= low_count + 32'h1;
        end
    end

    assign flags.rise = sync_level && !level_prev;
    assign flags.fall = !sync_level && level_prev;
    assign flags.low_held = low_full && !sync_level;

endmodule : event_input_conditioner

`default_nettype wire

//--- core/program_event_trap_unit.sv
// Purpose: Event trap and auxiliary functions of a pumping-program sequencer.
// Assumes: AHB-Lite slave, zero wait states, single word transfers.
// Notes: Functions are executed by writing the command register.
//
// The address map and the AHB-Lite slave port are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module program_event_trap_unit
    import program_event_trap_pkg::*;
#(
    parameter int LOW_HOLD = LOW_HOLD_CYCLES,
    parameter int BEEP_LENGTH = BEEP_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // External event pin and sequencer events
    input wire logic event_pin,
    input wire logic remote_event,
    input wire logic stop_key,
    input wire logic stop_trigger,
    input wire logic program_start,
    input wire logic infuse_step,
    input wire logic withdraw_step,
    // Sequencer control
    output logic jump_strobe,
    output logic [PHASE_W-1:0] jump_phase,
    output logic advance_strobe,
    output logic stop_pump,
    // Trigger modes
    output logic [MODE_W-1:0] start_trigger_mode,
    output logic [MODE_W-1:0] active_trigger_mode,
    // Pins
    output logic program_output,
    output logic buzzer
);

    // ==================================================================
    // Bus address phase capture
    logic addr_taken;
    logic wr_pending;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] next_hrdata;

    assign addr_taken = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            wr_pending <= addr_taken && hwrite;
            wr_addr <= haddr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==================================================================
    // Command decode
    command_type cmd;
    logic cmd_valid;
    logic default_write;
    logic do_trap_falling;
    logic do_trap_square;
    logic do_cancel;
    logic do_clear;
    logic do_override;
    logic do_button_redirect;
    logic do_trigger_redirect;
    logic do_output;
    logic do_beep;

    assign cmd.code = hwdata[CMD_CODE_LSB +: CODE_W];
    assign cmd.param = hwdata[CMD_PARAM_LSB +: PHASE_W];
    assign cmd_valid = wr_pending && (wr_addr == ADDR_COMMAND);
    assign default_write = wr_pending && (wr_addr == ADDR_DEFAULT_MODE);
    assign do_trap_falling = cmd_valid && (cmd.code == CMD_TRAP_FALLING);
    assign do_trap_square = cmd_valid && (cmd.code == CMD_TRAP_SQUARE);
    assign do_cancel = cmd_valid && (cmd.code == CMD_TRAP_CANCEL);
    assign do_clear = cmd_valid && (cmd.code == CMD_CLEAR_TOTALS);
    assign do_override = cmd_valid && (cmd.code == CMD_TRIGGER_OVERRIDE);
    assign do_button_redirect = cmd_valid
        && (cmd.code == CMD_BUTTON_REDIRECT);
    assign do_trigger_redirect = cmd_valid
        && (cmd.code == CMD_TRIGGER_REDIRECT);
    assign do_output = cmd_valid && (cmd.code == CMD_OUTPUT_SET);
    assign do_beep = cmd_valid && (cmd.code == CMD_BEEP);

    // ==================================================================
    // Event input conditioning
    event_flags_type flags;

    event_input_conditioner #(
        .HOLD_CYCLES(LOW_HOLD)
    ) u_conditioner (
        .hclk(hclk),
        .hresetn(hresetn),
        .event_pin(event_pin),
        .flags(flags)
    );

    // ==================================================================
    // Trap firing
    trap_state_type trap_state;
    trap_state_type next_trap_state;
    logic [PHASE_W-1:0] trap_phase;
    logic trap_armed;
    logic edge_fire;
    logic button_redirect;
    logic trigger_redirect;
    logic key_redirected;
    logic trig_redirected;
    logic redirected;
    logic fire_pending;
    logic fire_immediate;

    assign trap_armed = (trap_state != TRAP_IDLE);
    assign edge_fire = ((trap_state == TRAP_FALLING) && flags.fall)
        || ((trap_state == TRAP_SQUARE)
        && (flags.rise || flags.fall));
    assign key_redirected = stop_key && button_redirect;
    assign trig_redirected = stop_trigger && trigger_redirect;
    assign redirected = key_redirected || trig_redirected;
    // Both trap kinds share the same jump path
    assign fire_pending = trap_armed
        && (edge_fire || remote_event || redirected);
    assign fire_immediate = do_trap_falling && flags.low_held;

    // New arming wins the trap state over a same-cycle firing of the old trap, which still strobes jump_strobe
    always_comb begin
        next_trap_state = trap_state;
        if (do_trap_falling) begin
            next_trap_state = fire_immediate ? TRAP_IDLE
                : TRAP_FALLING;
        end else if (do_trap_square) begin
            next_trap_state = TRAP_SQUARE;
        end else if (do_cancel) begin
            next_trap_state = TRAP_IDLE;
        end else if (fire_pending) begin
            next_trap_state = TRAP_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_state <= TRAP_IDLE;
            trap_phase <= '0;
        end else begin
            trap_state <= next_trap_state;
            if (do_trap_falling || do_trap_square) begin
                trap_phase <= cmd.param;
            end
        end
    end

    // ==================================================================
    // Sequencer strobes
    logic beep_done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jump_strobe <= 1'b0;
            jump_phase <= '0;
            advance_strobe <= 1'b0;
            stop_pump <= 1'b0;
        end else begin
            jump_strobe <= fire_pending || fire_immediate;
            if (fire_immediate) begin
                jump_phase <= cmd.param;
            end else if (fire_pending) begin
                jump_phase <= trap_phase;
            end
            advance_strobe <= (redirected && !trap_armed)
                || beep_done;
            stop_pump <= (stop_key && !button_redirect)
                || (stop_trigger && !trigger_redirect);
        end
    end

    // ==================================================================
    // Redirect flags, one-shot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            button_redirect <= 1'b0;
            trigger_redirect <= 1'b0;
        end else begin
            if (do_button_redirect) begin
                button_redirect <= 1'b1;
            end else if (key_redirected) begin
                button_redirect <= 1'b0;
            end
            if (do_trigger_redirect) begin
                trigger_redirect <= 1'b1;
            end else if (trig_redirected) begin
                trigger_redirect <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Trigger modes
    logic [MODE_W-1:0] default_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            default_mode <= DEFAULT_MODE_RESET;
            start_trigger_mode <= DEFAULT_MODE_RESET;
            active_trigger_mode <= DEFAULT_MODE_RESET;
        end else begin
            if (default_write) begin
                default_mode <= hwdata[MODE_W-1:0];
            end
            start_trigger_mode <= default_mode;
            // Redirects have no path into the active mode
            if (do_override) begin
                active_trigger_mode <= cmd.param;
            end else if (program_start) begin
                active_trigger_mode <= default_mode;
            end
        end
    end

    // ==================================================================
    // Dispensed totals
    logic [TOTAL_W-1:0] infused_total;
    logic [TOTAL_W-1:0] withdrawn_total;
    logic [TOTAL_W-1:0] infused_base;
    logic [TOTAL_W-1:0] withdrawn_base;

    // A step that lands with the clear is still counted
    assign infused_base = do_clear ? '0 : infused_total;
    assign withdrawn_base = do_clear ? '0 : withdrawn_total;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            infused_total <= '0;
            withdrawn_total <= '0;
        end else begin
            infused_total <= infused_base + TOTAL_W'(infuse_step);
            withdrawn_total <= withdrawn_base + TOTAL_W'(withdraw_step);
        end
    end

    // ==================================================================
    // Output pin and buzzer
    logic [31:0] beep_count;

    assign beep_done = buzzer && (beep_count == 32'h1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_output <= 1'b0;
            buzzer <= 1'b0;
            beep_count <= 32'h0000_0000;
        end else begin
            if (do_output) begin
                program_output <= cmd.param[0];
            end
            if (do_beep) begin
                buzzer <= 1'b1;
                beep_count <= 32'(BEEP_LENGTH);
            end else if (beep_done) begin
                buzzer <= 1'b0;
                beep_count <= 32'h0000_0000;
            end else if (buzzer) begin
                beep_count <= beep_count - 32'h1;
            end
        end
    end

    // ==================================================================
    // Read multiplexer
    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[ST_ARMED] = trap_armed;
        status_word[ST_SQUARE] = (trap_state == TRAP_SQUARE);
        status_word[ST_BUTTON_REDIRECT] = button_redirect;
        status_word[ST_TRIGGER_REDIRECT] = trigger_redirect;
        status_word[ST_OUTPUT] = program_output;
        status_word[ST_BUZZER] = buzzer;
        status_word[ST_PHASE_LSB +: PHASE_W] = trap_phase;
    end

    always_comb begin
        next_hrdata = '0;
        if (addr_taken && !hwrite) begin
            case (haddr)
                ADDR_STATUS: next_hrdata = status_word;
                ADDR_DEFAULT_MODE: next_hrdata = DATA_W'(default_mode);
                ADDR_ACTIVE_MODE: next_hrdata = DATA_W'(active_trigger_mode);
                ADDR_INFUSED: next_hrdata = infused_total;
                ADDR_WITHDRAWN: next_hrdata = withdrawn_total;
                default: next_hrdata = '0;
            endcase
        end
    end

endmodule : program_event_trap_unit

`default_nettype wire

//--- sim/trap_host_model.sv
// Purpose: Trigger equipment and serial host.
// Assumes: Pulses last one hclk cycle.
// Notes: Event pin idles high.

`timescale 1ns/1ps
`default_nettype none

module trap_host_model (
    // Clock
    input wire logic hclk,
    // Event pin and pulses
    output logic event_pin = 1'b1,
    output logic remote_event = 1'b0,
    output logic stop_key = 1'b0,
    output logic stop_trigger = 1'b0
);
    // ====================================
    // Stimulus tasks
    task automatic set_pin(input logic level);
        @(posedge hclk);
        event_pin <= level;
    endtask : set_pin

    // Kind 0 remote command, 1 stop key, 2 stop trigger
    task automatic pulse(input int kind);
        @(posedge hclk);
        remote_event <= (kind == 0);
        stop_key <= (kind == 1);
        stop_trigger <= (kind == 2);
        @(posedge hclk);
        remote_event <= 1'b0;
        stop_key <= 1'b0;
        stop_trigger <= 1'b0;
    endtask : pulse
endmodule : trap_host_model

`default_nettype wire

//--- sim/program_event_trap_sva.sv
// Purpose: Port checks of the trap unit.
// Assumes: One clock, async low reset.
// Notes: Bound to every instance.

`timescale 1ns/1ps
`default_nettype none

module program_event_trap_sva
    import program_event_trap_pkg::*;
#(
    parameter int LOW_HOLD = LOW_HOLD_CYCLES,
    parameter int BEEP_LENGTH = BEEP_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // Events
    input wire logic stop_key,
    input wire logic stop_trigger,
    input wire logic program_start,
    // Outputs
    input wire logic jump_strobe,
    input wire logic [PHASE_W-1:0] jump_phase,
    input wire logic advance_strobe,
    input wire logic stop_pump,
    input wire logic [MODE_W-1:0] start_trigger_mode,
    input wire logic [MODE_W-1:0] active_trigger_mode,
    input wire logic program_output,
    input wire logic buzzer
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire write_taken = hsel && htrans[HTRANS_ACTIVE_BIT] && hwrite && hready;
    logic [31:0] beep_count;

    // ====================================
    // Buzzer on-time counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) beep_count <= '0;
        else beep_count <= buzzer ? beep_count + 1 : '0;
    end

    // ====================================
    // Assertions
    AST_KEY_ROUTED: assert property (stop_key |=>
        (jump_strobe || advance_strobe || stop_pump)) else $error("key lost");
    AST_TRIG_ROUTED: assert property (stop_trigger |=>
        (jump_strobe || advance_strobe || stop_pump)) else $error("trig lost");
    AST_STOP_CAUSE: assert property (stop_pump |->
        $past(stop_key || stop_trigger)) else $error("stray stop");
    AST_JUMP_ONCE: assert property (jump_strobe |=> !jump_strobe)
        else $error("jump repeated");
    AST_PHASE_WITH_JUMP: assert property ($changed(jump_phase) |->
        jump_strobe) else $error("phase moved");
    AST_MODE_KEPT: assert property ((stop_key || stop_trigger) &&
        !program_start && !write_taken |=> $stable(active_trigger_mode))
        else $error("mode moved");
    AST_START_DEFAULT: assert property (program_start && !write_taken
        |=> active_trigger_mode == start_trigger_mode)
        else $error("start mode");
    AST_OUTPUT_CAUSE: assert property ($changed(program_output) |->
        $past(write_taken, 2)) else $error("output moved");
    AST_BEEP_END: assert property ($fell(buzzer) |->
        beep_count == BEEP_LENGTH && advance_strobe)
        else $error("beep length");
    AST_BEEP_BOUND: assert property (buzzer |->
        beep_count < BEEP_LENGTH) else $error("beep too long");

    cover property (jump_strobe);
    cover property (stop_pump);
    cover property (advance_strobe && !buzzer);
endmodule : program_event_trap_sva

bind program_event_trap_unit program_event_trap_sva #(
    .LOW_HOLD(LOW_HOLD), .BEEP_LENGTH(BEEP_LENGTH)
) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .stop_key(stop_key),
    .stop_trigger(stop_trigger), .program_start(program_start),
    .jump_strobe(jump_strobe), .jump_phase(jump_phase),
    .advance_strobe(advance_strobe), .stop_pump(stop_pump),
    .start_trigger_mode(start_trigger_mode),
    .active_trigger_mode(active_trigger_mode),
    .program_output(program_output), .buzzer(buzzer)
);

`default_nettype wire

//--- sim/tb.sv
// Purpose: Self-checking bench of the trap unit.
// Assumes: Zero-wait slave; short counts.
// Notes: Reset reads and totals, then table rows, then hand cases.

`timescale 1ns/1ps
`default_nettype none

module tb
    import program_event_trap_pkg::*;
;
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [7:0] param;
        logic [ADDR_W-1:0] addr;
        logic [15:0] mask;
        logic [15:0] want;
    } row_type;

    localparam int SIM_HOLD = 20;
    localparam int SIM_BEEP = 10;

    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic program_start = 1'b0, infuse_step = 1'b0, withdraw_step = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [DATA_W-1:0] hwdata = '0;
    logic hready, hreadyout, hresp, jump_strobe, advance_strobe, stop_pump;
    logic event_pin, remote_event, stop_key, stop_trigger;
    logic program_output, buzzer;
    logic [DATA_W-1:0] hrdata, data;
    logic [PHASE_W-1:0] jump_phase;
    logic [MODE_W-1:0] start_trigger_mode, active_trigger_mode;
    row_type rows [8];
    int n_errors = 0, n_compared = 0, count;

    always #2.5 hclk = ~hclk;
    assign hready = hreadyout;

    program_event_trap_unit #(.LOW_HOLD(SIM_HOLD), .BEEP_LENGTH(SIM_BEEP)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .event_pin(event_pin), .remote_event(remote_event),
        .stop_key(stop_key), .stop_trigger(stop_trigger),
        .program_start(program_start), .infuse_step(infuse_step),
        .withdraw_step(withdraw_step), .jump_strobe(jump_strobe),
        .jump_phase(jump_phase), .advance_strobe(advance_strobe),
        .stop_pump(stop_pump), .start_trigger_mode(start_trigger_mode),
        .active_trigger_mode(active_trigger_mode),
        .program_output(program_output), .buzzer(buzzer)
    );

    trap_host_model host (
        .hclk(hclk), .event_pin(event_pin), .remote_event(remote_event),
        .stop_key(stop_key), .stop_trigger(stop_trigger)
    );

    // ====================================
    // Tasks
    task automatic complete_run();
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, got, want);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] want);
        bus(1'b0, a, '0, data);
        check(data, want);
    endtask : rdc

    task automatic cmd(input logic [CODE_W-1:0] code, input logic [7:0] p);
        bus(1'b1, ADDR_COMMAND, {16'h0000, p, 4'h0, code}, data);
    endtask : cmd

    // Bounded wait for {jump, advance, stop}
    task automatic expect_ev(input logic [2:0] want, input logic [7:0] ph);
        logic [2:0] got;
        got = 3'b000;
        for (int i = 0; i < 12 && got == 3'b000; i++) begin
            #1;
            got = {jump_strobe, advance_strobe, stop_pump};
            if (got == 3'b000) @(posedge hclk);
        end
        check(got, want);
        if (want[2]) check(jump_phase, ph);
    endtask : expect_ev

    // ====================================
    // Watchdog
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        complete_run();
    end

    // ====================================
    // Main sequence
    initial begin
        rows[0] = '{CMD_TRAP_FALLING, 8'h21, ADDR_STATUS, 16'hff03, 16'h2101};
        rows[1] = '{CMD_TRAP_SQUARE, 8'h33, ADDR_STATUS, 16'hff03, 16'h3303};
        rows[2] = '{CMD_TRAP_CANCEL, 8'h00, ADDR_STATUS, 16'h0001, 16'h0000};
        rows[3] = '{CMD_BUTTON_REDIRECT, 8'h00, ADDR_STATUS, 16'h000c, 16'h4};
        rows[4] = '{CMD_TRIGGER_REDIRECT, 8'h00, ADDR_STATUS, 16'h000c, 16'hc};
        rows[5] = '{CMD_OUTPUT_SET, 8'h01, ADDR_STATUS, 16'h0010, 16'h0010};
        rows[6] = '{CMD_OUTPUT_SET, 8'h00, ADDR_STATUS, 16'h0010, 16'h0000};
        rows[7] = '{CMD_TRIGGER_OVERRIDE, 8'h5a, ADDR_ACTIVE_MODE, 16'hff, 16'h5a};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(ADDR_STATUS, 32'h0);
        rdc(ADDR_DEFAULT_MODE, 32'h0);
        rdc(8'h18, 32'h0);
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            infuse_step <= 1'b1;
            withdraw_step <= (i < 2);
            @(posedge hclk);
            infuse_step <= 1'b0;
            withdraw_step <= 1'b0;
        end
        rdc(ADDR_INFUSED, 32'h3);
        rdc(ADDR_WITHDRAWN, 32'h2);
        cmd(CMD_CLEAR_TOTALS, 8'h00);
        rdc(ADDR_INFUSED, 32'h0);
        rdc(ADDR_WITHDRAWN, 32'h0);
        foreach (rows[i]) begin
            cmd(rows[i].code, rows[i].param);
            bus(1'b0, rows[i].addr, '0, data);
            check(data & rows[i].mask, rows[i].want);
            if (rows[i].code == CMD_OUTPUT_SET)
                check(program_output, rows[i].param[0]);
        end
        // Redirected stops, with and without a trap
        cmd(CMD_TRAP_SQUARE, 8'h44);
        host.pulse(1);
        expect_ev(3'b100, 8'h44);
        bus(1'b0, ADDR_STATUS, '0, data);
        check(data & 32'h5, 32'h0);
        host.pulse(1);
        expect_ev(3'b001, 8'h00);
        host.pulse(2);
        expect_ev(3'b010, 8'h00);
        rdc(ADDR_ACTIVE_MODE, 32'h5a);
        host.pulse(2);
        expect_ev(3'b001, 8'h00);
        // Square trap on both edges
        cmd(CMD_TRAP_SQUARE, 8'h50);
        host.set_pin(1'b0);
        expect_ev(3'b100, 8'h50);
        cmd(CMD_TRAP_SQUARE, 8'h51);
        host.set_pin(1'b1);
        expect_ev(3'b100, 8'h51);
        // Falling trap: edge, long low, rising ignored, remote
        cmd(CMD_TRAP_FALLING, 8'h60);
        host.set_pin(1'b0);
        expect_ev(3'b100, 8'h60);
        repeat (SIM_HOLD + 4) @(posedge hclk);
        cmd(CMD_TRAP_FALLING, 8'h61);
        expect_ev(3'b100, 8'h61);
        host.set_pin(1'b1);
        repeat (5) @(posedge hclk);
        host.set_pin(1'b0);
        repeat (5) @(posedge hclk);
        cmd(CMD_TRAP_FALLING, 8'h62);
        host.set_pin(1'b1);
        expect_ev(3'b000, 8'h00);
        host.pulse(0);
        expect_ev(3'b100, 8'h62);
        host.pulse(0);
        expect_ev(3'b000, 8'h00);
        cmd(CMD_TRAP_SQUARE, 8'h70);
        cmd(CMD_TRAP_CANCEL, 8'h00);
        host.set_pin(1'b0);
        expect_ev(3'b000, 8'h00);
        // Beep length and completion
        cmd(CMD_BEEP, 8'h00);
        #1;
        count = 0;
        while (buzzer === 1'b1 && count < 40) begin
            @(posedge hclk);
            #1;
            count++;
        end
        check(count, SIM_BEEP);
        check(advance_strobe, 32'h1);
        // Start uses the default mode
        bus(1'b1, ADDR_DEFAULT_MODE, 32'h3c, data);
        rdc(ADDR_DEFAULT_MODE, 32'h3c);
        check(start_trigger_mode, 32'h3c);
        rdc(ADDR_ACTIVE_MODE, 32'h5a);
        @(posedge hclk);
        program_start <= 1'b1;
        @(posedge hclk);
        program_start <= 1'b0;
        rdc(ADDR_ACTIVE_MODE, 32'h3c);
        // Reset in mid-run
        cmd(CMD_OUTPUT_SET, 8'h01);
        cmd(CMD_TRAP_SQUARE, 8'h7f);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        check({program_output, hreadyout, hresp}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(ADDR_STATUS, 32'h0);
        complete_run();
    end
endmodule : tb

`default_nettype wire
